// *** ssc_defs.svh ***
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
// Summary of operation
// - master holds slave select high when idle, low for each transfer; with ss_hold set, select stays low in idle after a transfer
// - device software enables select control when slave uses clock-edge select
// - device software keeps input_sample_phase clear while acting as slave
// - both I2C lines are open drain, pulled low for zero
// - master sends start, then slave address, then direction bit
// - addressed slave acknowledges the address, then data flows
// - receiving master answers the final byte with not-acknowledge
// - stop is data rising while clock is high
// - master keeping the bus sends restart instead of stop
// - master waits while a slave holds the clock line low
// - nine-bit units, eight data bits first, then acknowledge
// - data changes while clock low, sampled on clock rising edge

// timing
`define SSC_CLK_MHZ 125
`define SSC_SPI_HALF_NS 500
`define SSC_I2C_HALF_NS 5000

// register byte offsets
`define SSC_OFS_CTRL 5'h00
`define SSC_OFS_SPI_DATA 5'h04
`define SSC_OFS_I2C_CMD 5'h08
`define SSC_OFS_STATUS 5'h0C
`define SSC_OFS_RX 5'h10

// fields
`define SSC_CTRL_SS_HOLD 0
`define SSC_CMD_LSB 8
`define SSC_ST_SPI_BUSY 0
`define SSC_ST_I2C_BUSY 1
`define SSC_ST_I2C_OWN 2
`define SSC_ST_BUS_BUSY 3
`define SSC_ST_NACK 4
`define SSC_ST_ARB_LOST 5
`define SSC_ST_REFUSED 6
`define SSC_RX_I2C_LSB 8

// reset values
`define SSC_RST_BYTE 8'h00
`define SSC_RST_RDATA 32'h0000_0000
`endif

// *** ssc_pkg.sv ***
package ssc_pkg;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_START = 3'h1, CMD_WRITE = 3'h2, CMD_READ_ACK = 3'h3,
    CMD_READ_NACK = 3'h4, CMD_STOP = 3'h5, CMD_RESTART = 3'h6, CMD_SPARE = 3'h7
  } ssc_cmd_e;
  typedef enum logic [3:0] {
    SPI_IDLE = 4'h1, SPI_LOW = 4'h2, SPI_HIGH = 4'h4, SPI_TAIL = 4'h8
  } ssc_spi_st_e;
  typedef enum logic [12:0] {
    I2C_IDLE = 13'h0001, I2C_ST_SDA = 13'h0002, I2C_ST_SCL = 13'h0004,
    I2C_HOLD = 13'h0008, I2C_B_LOW = 13'h0010, I2C_B_RISE = 13'h0020,
    I2C_B_HIGH = 13'h0040, I2C_SP_LOW = 13'h0080, I2C_SP_RISE = 13'h0100,
    I2C_SP_HIGH = 13'h0200, I2C_SP_END = 13'h0400, I2C_RS_LOW = 13'h0800,
    I2C_RS_RISE = 13'h1000
  } ssc_i2c_st_e;
  typedef struct packed {logic start; logic hold_ss; logic [7:0] tx;} ssc_spi_req_s;
  typedef struct packed {logic busy; logic [7:0] rx;} ssc_spi_rsp_s;
  typedef struct packed {logic sck; logic ss_n; logic mosi;} ssc_spi_pins_s;
  typedef struct packed {logic [2:0] meta; logic [2:0] stable;} ssc_sync_s;
  typedef struct packed {
    ssc_spi_st_e st; logic [5:0] cnt; logic [2:0] bit_n; logic [7:0] sh;
    ssc_spi_rsp_s rsp; ssc_spi_pins_s pins;
  } ssc_spi_s;
  typedef struct packed {
    ssc_i2c_st_e st; logic [9:0] cnt; logic [3:0] bit_n; logic [8:0] tx;
    logic [7:0] rx; logic rd; logic pend_start; logic scl_oe; logic sda_oe;
    logic drive_lvl; logic bus_busy; logic scl_d; logic sda_d; logic arb_lost;
    logic refused; logic nack; logic ss_hold; logic [7:0] spi_tx;
    logic spi_start; logic wreq; logic [31:0] rdata;
  } ssc_top_s;
endpackage

// *** ssc_sync.sv ***
`timescale 1ns/1ps
module ssc_sync (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_async,
  output logic [2:0] o_sync
);
  ssc_pkg::ssc_sync_s r_reg;
  ssc_pkg::ssc_sync_s r_next;
  // two flops per line, second stage is the only reader of the first
  always_comb begin
    r_next = r_reg;
    r_next.meta = i_async;
    r_next.stable = r_reg.meta;
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) r_reg <= '0;
    else r_reg <= r_next;
  end
  // one output per synchronised line
  for (genvar g = 0; g < 3; g++) begin : g_out
    assign o_sync[g] = r_reg.stable[g];
  end
endmodule // ssc_sync

// *** ssc_spi_master.sv ***
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_spi_master (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire ssc_pkg::ssc_spi_req_s i_req,
  input wire logic i_miso_sync,
  output ssc_pkg::ssc_spi_rsp_s o_rsp,
  output ssc_pkg::ssc_spi_pins_s o_pins
);
  localparam logic [5:0] HALF = 6'((`SSC_SPI_HALF_NS * `SSC_CLK_MHZ + 999) / 1000 - 1);
  ssc_pkg::ssc_spi_s r_reg;
  ssc_pkg::ssc_spi_s r_next;
  // clock idles low, data set while low, sampled on the rising edge, msb first
  always_comb begin
    r_next = r_reg;
    r_next.cnt = (r_reg.cnt == 6'h00) ? r_reg.cnt : r_reg.cnt - 6'h01;
    unique case (r_reg.st)
      ssc_pkg::SPI_IDLE: begin
        if (!i_req.hold_ss) r_next.pins.ss_n = 1'b1;
        if (i_req.start) begin
          r_next.st = ssc_pkg::SPI_LOW;
          r_next.pins.ss_n = 1'b0; // select driven low for every byte
          r_next.sh = i_req.tx;
          r_next.pins.mosi = i_req.tx[7];
          r_next.bit_n = 3'h0;
          r_next.cnt = HALF;
          r_next.rsp.busy = 1'b1;
        end
      end
      ssc_pkg::SPI_LOW: if (r_reg.cnt == 6'h00) begin
        r_next.st = ssc_pkg::SPI_HIGH;
        r_next.pins.sck = 1'b1;
        r_next.sh = {r_reg.sh[6:0], i_miso_sync};
        r_next.cnt = HALF;
      end
      ssc_pkg::SPI_HIGH: if (r_reg.cnt == 6'h00) begin
        r_next.pins.sck = 1'b0;
        r_next.cnt = HALF;
        if (r_reg.bit_n == 3'h7) begin
          r_next.st = ssc_pkg::SPI_TAIL;
          r_next.rsp.rx = r_reg.sh;
        end else begin
          r_next.st = ssc_pkg::SPI_LOW;
          r_next.bit_n = r_reg.bit_n + 3'h1;
          r_next.pins.mosi = r_reg.sh[7]; // half a bit before sampling
        end
      end
      ssc_pkg::SPI_TAIL: if (r_reg.cnt == 6'h00) begin
        r_next.st = ssc_pkg::SPI_IDLE;
        r_next.rsp.busy = 1'b0;
        r_next.pins.ss_n = ~i_req.hold_ss;
      end
    endcase
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      r_reg <= '0;
      r_reg.st <= ssc_pkg::SPI_IDLE;
      r_reg.pins.ss_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end
  assign o_rsp = r_reg.rsp;
  assign o_pins = r_reg.pins;
endmodule // ssc_spi_master

// *** ssc_top.sv ***
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_top (
  input wire logic i_clk,
  input wire logic i_reset,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // spi master pins
  output logic o_spi_sck,
  output logic o_spi_ss_n,
  output logic o_spi_mosi,
  input wire logic i_spi_miso,
  // i2c open-drain pins
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);
  localparam logic [9:0] HALF = 10'((`SSC_I2C_HALF_NS * `SSC_CLK_MHZ + 999) / 1000 - 1);

  ssc_pkg::ssc_top_s r_reg;
  ssc_pkg::ssc_top_s r_next;
  ssc_pkg::ssc_spi_req_s spi_req;
  ssc_pkg::ssc_spi_rsp_s spi_rsp;
  ssc_pkg::ssc_spi_pins_s spi_pins;
  logic [2:0] sync_out;
  logic s_scl;
  logic s_sda;
  logic s_miso;
  logic start_det;
  logic stop_det;
  logic req;
  logic take;
  logic finish;
  logic tick;
  logic i2c_busy;
  ssc_pkg::ssc_cmd_e cmd;

  // pin inputs pass two flops before any use
  ssc_sync u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_spi_miso, i_sda, i_scl}),
    .o_sync(sync_out)
  );
  assign s_scl = sync_out[0];
  assign s_sda = sync_out[1];
  assign s_miso = sync_out[2];

  // byte-wide spi engine
  assign spi_req = '{start: r_reg.spi_start, hold_ss: r_reg.ss_hold, tx: r_reg.spi_tx};
  ssc_spi_master u_spi (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_req(spi_req),
    .i_miso_sync(s_miso),
    .o_rsp(spi_rsp),
    .o_pins(spi_pins)
  );

  // bus condition detect on synchronised lines, one cycle apart
  assign start_det = r_reg.scl_d & s_scl & r_reg.sda_d & ~s_sda;
  assign stop_det = r_reg.scl_d & s_scl & ~r_reg.sda_d & s_sda;

  // bus handshake: first cycle of a request drops waitrequest next edge
  assign req = i_avs_read | i_avs_write;
  assign take = req & r_reg.wreq;
  assign finish = req & ~r_reg.wreq;
  assign tick = (r_reg.cnt == 10'h000);
  assign cmd = ssc_pkg::ssc_cmd_e'(i_avs_writedata[`SSC_CMD_LSB+2:`SSC_CMD_LSB]);
  assign i2c_busy = r_reg.pend_start |
                    ~(r_reg.st == ssc_pkg::I2C_IDLE || r_reg.st == ssc_pkg::I2C_HOLD);

  always_comb begin
    r_next = r_reg;
    r_next.spi_start = 1'b0;
    r_next.scl_d = s_scl;
    r_next.sda_d = s_sda;
    r_next.cnt = tick ? r_reg.cnt : r_reg.cnt - 10'h001;

    // bus busy tracking from observed conditions
    if (start_det) r_next.bus_busy = 1'b1;
    else if (stop_det) r_next.bus_busy = 1'b0;

    // register access
    r_next.wreq = ~take;
    if (take && i_avs_read) begin
      r_next.rdata = `SSC_RST_RDATA;
      unique case (i_avs_address)
        `SSC_OFS_CTRL: r_next.rdata[`SSC_CTRL_SS_HOLD] = r_reg.ss_hold;
        `SSC_OFS_SPI_DATA: r_next.rdata[7:0] = r_reg.spi_tx;
        `SSC_OFS_STATUS: begin
          r_next.rdata[`SSC_ST_SPI_BUSY] = spi_rsp.busy;
          r_next.rdata[`SSC_ST_I2C_BUSY] = i2c_busy;
          r_next.rdata[`SSC_ST_I2C_OWN] = (r_reg.st == ssc_pkg::I2C_HOLD);
          r_next.rdata[`SSC_ST_BUS_BUSY] = r_reg.bus_busy;
          r_next.rdata[`SSC_ST_NACK] = r_reg.nack;
          r_next.rdata[`SSC_ST_ARB_LOST] = r_reg.arb_lost;
          r_next.rdata[`SSC_ST_REFUSED] = r_reg.refused;
        end
        `SSC_OFS_RX: begin
          r_next.rdata[7:0] = spi_rsp.rx;
          r_next.rdata[`SSC_RX_I2C_LSB+7:`SSC_RX_I2C_LSB] = r_reg.rx;
        end
        default: r_next.rdata = `SSC_RST_RDATA; // unmapped reads zero
      endcase
    end
    if (finish && i_avs_write) begin
      unique case (i_avs_address)
        `SSC_OFS_CTRL: r_next.ss_hold = i_avs_writedata[`SSC_CTRL_SS_HOLD];
        `SSC_OFS_SPI_DATA: begin
          // a write while a byte is in flight is dropped and flagged
          if (spi_rsp.busy) begin
            r_next.refused = 1'b1;
          end else begin
            r_next.spi_tx = i_avs_writedata[7:0];
            r_next.spi_start = 1'b1;
          end
        end
        `SSC_OFS_STATUS: begin
          // write one to clear sticky flags
          if (i_avs_writedata[`SSC_ST_ARB_LOST]) r_next.arb_lost = 1'b0;
          if (i_avs_writedata[`SSC_ST_REFUSED]) r_next.refused = 1'b0;
        end
        `SSC_OFS_I2C_CMD: begin
          unique case (cmd)
            ssc_pkg::CMD_START: begin
              // start is queued until the bus is idle
              if (r_reg.st == ssc_pkg::I2C_IDLE && !r_reg.pend_start)
                r_next.pend_start = 1'b1;
              else
                r_next.refused = 1'b1;
            end
            ssc_pkg::CMD_WRITE, ssc_pkg::CMD_READ_ACK, ssc_pkg::CMD_READ_NACK: begin
              if (r_reg.st == ssc_pkg::I2C_HOLD) begin
                r_next.st = ssc_pkg::I2C_B_LOW;
                r_next.cnt = HALF;
                r_next.bit_n = 4'h0;
                r_next.rd = (cmd != ssc_pkg::CMD_WRITE);
                // eight data bits, then a released or driven ack slot
                if (cmd == ssc_pkg::CMD_WRITE)
                  r_next.tx = {i_avs_writedata[7:0], 1'b1};
                else if (cmd == ssc_pkg::CMD_READ_NACK)
                  r_next.tx = 9'h1FF;
                else
                  r_next.tx = 9'h1FE;
              end else begin
                r_next.refused = 1'b1;
              end
            end
            ssc_pkg::CMD_STOP: begin
              if (r_reg.st == ssc_pkg::I2C_HOLD) begin
                r_next.st = ssc_pkg::I2C_SP_LOW;
                r_next.cnt = HALF;
              end else begin
                r_next.refused = 1'b1;
              end
            end
            ssc_pkg::CMD_RESTART: begin
              if (r_reg.st == ssc_pkg::I2C_HOLD) begin
                r_next.st = ssc_pkg::I2C_RS_LOW;
                r_next.cnt = HALF;
              end else begin
                r_next.refused = 1'b1;
              end
            end
            default: r_next.refused = 1'b1;
          endcase
        end
        default: ; // unmapped writes are ignored
      endcase
    end

    // i2c master engine; lines are only ever pulled low or released
    unique case (r_reg.st)
      ssc_pkg::I2C_IDLE: begin
        r_next.scl_oe = 1'b0;
        r_next.sda_oe = 1'b0;
        // begin only on a quiet bus with both lines high
        if (r_reg.pend_start && !r_reg.bus_busy && !start_det && s_scl && s_sda) begin
          r_next.pend_start = 1'b0;
          r_next.st = ssc_pkg::I2C_ST_SDA;
          r_next.cnt = HALF;
        end
      end
      ssc_pkg::I2C_ST_SDA: if (tick) begin
        // data falls while clock is high
        r_next.sda_oe = 1'b1;
        r_next.st = ssc_pkg::I2C_ST_SCL;
        r_next.cnt = HALF;
      end
      ssc_pkg::I2C_ST_SCL: if (tick) begin
        r_next.scl_oe = 1'b1;
        r_next.st = ssc_pkg::I2C_HOLD;
      end
      ssc_pkg::I2C_HOLD: r_next.scl_oe = 1'b1; // clock held low between units
      ssc_pkg::I2C_B_LOW: begin
        // data set one cycle after clock went low
        r_next.sda_oe = ~r_reg.tx[8];
        if (tick) begin
          r_next.scl_oe = 1'b0;
          r_next.st = ssc_pkg::I2C_B_RISE;
        end
      end
      ssc_pkg::I2C_B_RISE: begin
        // a slave holding the clock low stalls us here
        if (s_scl) begin
          if (!r_reg.rd && r_reg.bit_n != 4'h8 && r_reg.tx[8] && !s_sda) begin
            // lost arbitration: release both lines, wait for a stop
            r_next.sda_oe = 1'b0;
            r_next.scl_oe = 1'b0;
            r_next.arb_lost = 1'b1;
            r_next.st = ssc_pkg::I2C_IDLE;
          end else begin
            if (r_reg.bit_n == 4'h8) begin
              if (!r_reg.rd) r_next.nack = s_sda;
            end else begin
              r_next.rx = {r_reg.rx[6:0], s_sda};
            end
            r_next.st = ssc_pkg::I2C_B_HIGH;
            r_next.cnt = HALF;
          end
        end
      end
      ssc_pkg::I2C_B_HIGH: if (tick) begin
        r_next.scl_oe = 1'b1;
        if (r_reg.bit_n == 4'h8) begin
          r_next.st = ssc_pkg::I2C_HOLD;
        end else begin
          r_next.bit_n = r_reg.bit_n + 4'h1;
          r_next.tx = {r_reg.tx[7:0], 1'b1};
          r_next.st = ssc_pkg::I2C_B_LOW;
          r_next.cnt = HALF;
        end
      end
      ssc_pkg::I2C_SP_LOW: begin
        // pull data low under the low clock, then free the clock
        r_next.sda_oe = 1'b1;
        if (tick) begin
          r_next.scl_oe = 1'b0;
          r_next.st = ssc_pkg::I2C_SP_RISE;
        end
      end
      ssc_pkg::I2C_SP_RISE: if (s_scl) begin
        r_next.st = ssc_pkg::I2C_SP_HIGH;
        r_next.cnt = HALF;
      end
      ssc_pkg::I2C_SP_HIGH: if (tick) begin
        r_next.sda_oe = 1'b0;
        r_next.st = ssc_pkg::I2C_SP_END;
        r_next.cnt = HALF;
      end
      ssc_pkg::I2C_SP_END: if (tick) r_next.st = ssc_pkg::I2C_IDLE;
      ssc_pkg::I2C_RS_LOW: begin
        // free data under the low clock, then raise the clock for a new start
        r_next.sda_oe = 1'b0;
        if (tick) begin
          r_next.scl_oe = 1'b0;
          r_next.st = ssc_pkg::I2C_RS_RISE;
        end
      end
      ssc_pkg::I2C_RS_RISE: if (s_scl) begin
        r_next.st = ssc_pkg::I2C_ST_SDA;
        r_next.cnt = HALF;
      end
    endcase
  end

  // single state register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      r_reg <= '0;
      r_reg.st <= ssc_pkg::I2C_IDLE;
      r_reg.wreq <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign o_avs_readdata = r_reg.rdata;
  assign o_avs_waitrequest = r_reg.wreq;
  assign o_scl = r_reg.drive_lvl;
  assign o_sda = r_reg.drive_lvl;
  assign o_scl_oe = r_reg.scl_oe;
  assign o_sda_oe = r_reg.sda_oe;
  assign o_spi_sck = spi_pins.sck;
  assign o_spi_ss_n = spi_pins.ss_n;
  assign o_spi_mosi = spi_pins.mosi;
endmodule // ssc_top

// *** ssc_top_props.sv ***
`timescale 1ns/1ps
module ssc_top_props (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_spi_sck,
  input wire logic o_spi_ss_n,
  input wire logic o_spi_mosi,
  input wire logic i_spi_miso,
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe
);
  // one domain: clock and reset given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // spi frame shape
  a_ss_idle_sck: assert property (o_spi_ss_n |-> !o_spi_sck)
    else $error("sck toggles while deselected");
  a_ss_lead: assert property ($fell(o_spi_ss_n) |-> ##63 $rose(o_spi_sck))
    else $error("select lead time wrong");
  a_sck_half: assert property ($rose(o_spi_sck) |-> ##63 $fell(o_spi_sck))
    else $error("sck high time wrong");
  a_mosi_edge: assert property ($changed(o_spi_mosi) && !o_spi_ss_n
    |-> $fell(o_spi_sck) || $fell(o_spi_ss_n))
    else $error("mosi moved off the falling edge");
  // i2c line conditions
  a_open_drain: assert property (!o_scl && !o_sda)
    else $error("line driven high");
  a_start_cond: assert property ($rose(o_sda_oe) && !o_scl_oe
    |-> i_scl && $past(i_sda))
    else $error("start without idle high lines");
  a_stop_cond: assert property ($fell(o_sda_oe) && !o_scl_oe && !$fell(o_scl_oe)
    |-> i_scl)
    else $error("data released while clock low");
  a_scl_wait: assert property (!o_scl_oe && !i_scl && !$past(i_scl)
    |=> !o_scl_oe && $stable(o_sda_oe))
    else $error("master moved during stretch");
  // register bus answers after one wait cycle
  a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("waitrequest not low after one cycle");
  c_spi: cover property ($fell(o_spi_ss_n));
  c_start: cover property ($rose(o_sda_oe) && !o_scl_oe);
  c_stretch: cover property (!o_scl_oe && !i_scl);
endmodule // ssc_top_props

bind ssc_top ssc_top_props ssc_top_props_i (.i_clk, .i_reset, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_spi_sck,
  .o_spi_ss_n, .o_spi_mosi, .i_spi_miso, .i_scl, .o_scl, .o_scl_oe, .i_sda, .o_sda,
  .o_sda_oe);

// *** ssc_dev_model.sv ***
`timescale 1ns/1ps
module ssc_dev_model #(
  parameter logic [6:0] ADDR = 7'h52,
  parameter logic [7:0] RD_BYTE = 8'hC3,
  parameter logic [7:0] SPI_TX = 8'h3C,
  parameter int STRETCH = 700
) (
  input wire logic i_clk,
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  output logic o_miso,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low,
  output logic [7:0] o_rx,
  output logic [7:0] o_bytes
);
  localparam logic [3:0] SER_MODE = 4'h4; // slave with select control
  localparam logic SAMPLE_PH = 1'b0; // input_sample_phase kept clear
  logic sckp = 1'b0;
  logic sp = 1'b1;
  logic dp = 1'b1;
  logic hit = 1'b0;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic [7:0] stx = SPI_TX;
  logic [7:0] sh = 8'h00;
  logic [3:0] sbit = 4'h0;
  logic [3:0] bc = 4'h0;
  int cnt = 0;
  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
    o_bytes = 8'h00;
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // spi slave; sck edges found with the system clock
  // shifter is never stalled by its core, only the master side may freeze
  always @(posedge i_clk) begin
    sckp <= i_sck;
    if (i_ss_n) begin // logic reset, line toggled every cycle
      sbit <= 4'h0;
      stx <= SPI_TX;
      o_miso <= ~o_miso;
    end else begin
      o_miso <= stx[7]; // driven while selected
      if (i_sck && !sckp) begin
        o_rx <= {o_rx[6:0], i_mosi};
        sbit <= sbit + 4'h1;
        if (sbit == 4'h7) o_bytes <= o_bytes + 8'h01; // full byte flagged
      end
      if (!i_sck && sckp) stx <= {stx[6:0], 1'b0};
    end
  end
  // i2c slave, pulls lines low only
  always @(posedge i_clk) begin
    sp <= i_scl;
    dp <= i_sda;
    if (cnt != 0) cnt <= cnt - 1;
    else o_scl_low <= 1'b0; // stretch ends
    if (sp && i_scl && dp && !i_sda) begin // start or restart
      bc <= 4'h0;
      first <= 1'b1;
      hit <= 1'b0;
      o_sda_low <= 1'b0;
    end else if (sp && i_scl && !dp && i_sda) begin // stop
      bc <= 4'h0;
      hit <= 1'b0;
      o_sda_low <= 1'b0;
    end else if (i_scl && !sp) begin // sample on rising
      bc <= bc + 4'h1;
      if (bc < 4'h8) sh <= {sh[6:0], i_sda}; // msb first
      if (bc == 4'h8 && rd && !first && i_sda) hit <= 1'b0; // nack ends read
    end else if (!i_scl && sp) begin // change while low
      if (bc == 4'h8 && first) begin // own address acked
        hit <= sh[7:1] == ADDR;
        rd <= sh[0];
        o_sda_low <= sh[7:1] == ADDR;
      end else if (bc == 4'h8) begin
        o_sda_low <= hit && !rd; // ninth bit
      end else if (bc == 4'h9) begin
        bc <= 4'h0;
        first <= 1'b0;
        o_scl_low <= hit; // hold clock
        cnt <= STRETCH;
        o_sda_low <= hit && rd && !RD_BYTE[7];
      end else begin
        o_sda_low <= hit && rd && !first && !RD_BYTE[3'd7 - bc[2:0]];
      end
    end
  end
endmodule // ssc_dev_model

// *** tb.sv ***
`timescale 1ns/1ps
`include "ssc_defs.svh"
module tb;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] i_avs_address = 5'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_spi_sck, o_spi_ss_n, o_spi_mosi, o_scl, o_scl_oe, o_sda, o_sda_oe;
  logic i_spi_miso, scl_low, sda_low;
  logic rival_low = 1'b0;
  logic [7:0] dev_rx, dev_bytes;
  logic [31:0] rd;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  // open-drain wires with pull-ups
  wire i_scl = ~(o_scl_oe | scl_low);
  wire i_sda = ~(o_sda_oe | sda_low | rival_low);
  always #4 i_clk = ~i_clk;
  ssc_top ssc_top_i (.i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_spi_sck, .o_spi_ss_n,
    .o_spi_mosi, .i_spi_miso, .i_scl, .o_scl, .o_scl_oe, .i_sda, .o_sda, .o_sda_oe);
  ssc_dev_model ssc_dev_model_i (.i_clk(i_clk), .i_sck(o_spi_sck), .i_ss_n(o_spi_ss_n),
    .i_mosi(o_spi_mosi), .o_miso(i_spi_miso), .i_scl(i_scl), .i_sda(i_sda),
    .o_scl_low(scl_low), .o_sda_low(sda_low), .o_rx(dev_rx), .o_bytes(dev_bytes));
  task automatic complete_run;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, entered just after a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= ~w;
    // request stands until waitrequest is sampled low at a rising edge
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic poll(input int b);
    do bus(1'b0, `SSC_OFS_STATUS, 32'h0); while (rd[b] !== 1'b0);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] b);
    bus(1'b1, `SSC_OFS_I2C_CMD, {21'h0, c, b});
    poll(`SSC_ST_I2C_BUSY);
  endtask
  task automatic t_reset;
    chk({28'h0, o_spi_ss_n, o_spi_sck, o_scl_oe, o_sda_oe}, 32'h8);
    bus(1'b1, `SSC_OFS_CTRL, 32'h1);
    bus(1'b0, `SSC_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, o_spi_ss_n}, 32'h1);
    bus(1'b1, `SSC_OFS_CTRL, 32'h0);
    bus(1'b1, 5'h18, 32'hFFFF_FFFF);
    bus(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `SSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `SSC_OFS_RX, 32'h0);
    chk(rd, `SSC_RST_RDATA);
  endtask
  task automatic t_spi;
    bus(1'b1, `SSC_OFS_SPI_DATA, 32'hA5);
    bus(1'b1, `SSC_OFS_SPI_DATA, 32'h11);
    poll(`SSC_ST_SPI_BUSY);
    chk(rd & 32'h40, 32'h40);
    chk({24'h0, dev_rx}, 32'hA5);
    bus(1'b0, `SSC_OFS_SPI_DATA, 32'h0);
    chk(rd & 32'hFF, 32'hA5);
    chk({31'h0, o_spi_ss_n}, 32'h1);
    bus(1'b0, `SSC_OFS_RX, 32'h0);
    chk(rd & 32'hFF, 32'h3C);
    bus(1'b1, `SSC_OFS_STATUS, 32'h40);
    bus(1'b1, `SSC_OFS_SPI_DATA, 32'h5A);
    poll(`SSC_ST_SPI_BUSY);
    chk(rd & 32'h40, 32'h0);
    chk({16'h0, dev_bytes, dev_rx}, 32'h025A);
  endtask
  task automatic t_i2c;
    cmd(ssc_pkg::CMD_START, 8'h00);
    chk(rd & 32'h0C, 32'h0C);
    cmd(ssc_pkg::CMD_WRITE, {7'h52, 1'b1});
    chk(rd & 32'h10, 32'h0);
    cmd(ssc_pkg::CMD_READ_NACK, 8'h00);
    bus(1'b0, `SSC_OFS_RX, 32'h0);
    chk(rd & 32'hFF00, 32'hC300);
    cmd(ssc_pkg::CMD_STOP, 8'h00);
    chk(rd & 32'h0C, 32'h0);
    chk({30'h0, i_scl, i_sda}, 32'h3);
    cmd(ssc_pkg::CMD_START, 8'h00);
    cmd(ssc_pkg::CMD_WRITE, {7'h11, 1'b0});
    chk(rd & 32'h10, 32'h10);
    cmd(ssc_pkg::CMD_RESTART, 8'h00);
    cmd(ssc_pkg::CMD_WRITE, {7'h52, 1'b0});
    cmd(ssc_pkg::CMD_WRITE, 8'h96);
    chk(rd & 32'h14, 32'h04);
    cmd(ssc_pkg::CMD_STOP, 8'h00);
  endtask
  task automatic t_arb;
    cmd(ssc_pkg::CMD_START, 8'h00);
    rival_low <= 1'b1; // a second master holds data low
    cmd(ssc_pkg::CMD_WRITE, 8'hFF);
    chk(rd & 32'h24, 32'h20);
    chk({30'h0, o_scl_oe, o_sda_oe}, 32'h0);
    bus(1'b1, `SSC_OFS_STATUS, 32'h20);
    bus(1'b1, `SSC_OFS_I2C_CMD, {21'h0, ssc_pkg::CMD_START, 8'h00}); // queued, bus busy
    bus(1'b0, `SSC_OFS_STATUS, 32'h0);
    chk(rd & 32'h2E, 32'h0A);
    rival_low <= 1'b0; // rival ends with a stop
    poll(`SSC_ST_I2C_BUSY);
    chk(rd & 32'h04, 32'h04);
    cmd(ssc_pkg::CMD_STOP, 8'h00);
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset;
    t_spi;
    t_i2c;
    t_arb;
    complete_run;
  end
endmodule // tb
